// file: logic/cssu_pkg.sv
// Constants, types and fuse decode tables for the clock source select and start-up block.
// Assumes one 20 MHz system clock; source and watchdog ticks arrive as pin-level toggles.
// Operation
// - Decode four fuse bits into clock source
// - Fuse one means unprogrammed, zero programmed
// - Wake start-up counted in source cycles
// - Reset adds none, 4K or 64K watchdog cycles
// - Factory default fuses 0001 and 10
// - Crystal range from upper three fuse bits
// - Crystal start-up table, lowest bit zero
// - Crystal start-up table, lowest bit one
// - Each clock domain gated on its own
// - Core clock gate halts core work
// - Async interrupt detect with peripheral clock off
// - Two-wire address match with peripheral clock off
// - Program memory clock follows core clock
// - Async timer clock runs during sleep
// - Converter clock runs with core stopped
package cssu_pkg;
	// Clock source kinds
	typedef enum logic [2:0] {
		CSSU_SRC_EXT_CLK = 3'h0,
		CSSU_SRC_INT_RC = 3'h1,
		CSSU_SRC_EXT_RC = 3'h2,
		CSSU_SRC_LF_XTAL = 3'h3,
		CSSU_SRC_XTAL = 3'h4
	} cssu_src_e;
	// Crystal amplifier range
	typedef enum logic [1:0] {
		CSSU_RNG_LOW = 2'h0,
		CSSU_RNG_MID = 2'h1,
		CSSU_RNG_HIGH = 2'h2,
		CSSU_RNG_WIDE = 2'h3
	} cssu_rng_e;
	// Reset delay selection
	typedef enum logic [1:0] {
		CSSU_DLY_NONE = 2'h0,
		CSSU_DLY_SHORT = 2'h1,
		CSSU_DLY_LONG = 2'h2
	} cssu_dly_e;
	// Fuse bundle
	typedef struct packed {
		logic [3:0] clock_source_select_fuses;
		logic [1:0] startup_time_fuses;
		logic oscillator_swing_option_fuse;
	} cssu_fuse_s;
	// Domain gate bundle from sleep control
	typedef struct packed {
		logic core_run;
		logic periph_run;
		logic async_run;
		logic conv_run;
	} cssu_gate_s;
	// Fuse value meaning unprogrammed
	localparam logic CSSU_FUSE_UNPROG = 1'h1;
	// Factory default fuse values
	localparam logic [3:0] CSSU_DEF_CKSRC = 4'h1;
	localparam logic [1:0] CSSU_DEF_START = 2'h2;
	// Source decode boundaries
	localparam logic [3:0] CSSU_XTAL_MIN = 4'ha;
	localparam logic [3:0] CSSU_LF_CODE = 4'h9;
	localparam logic [3:0] CSSU_ERC_MIN = 4'h5;
	localparam logic [3:0] CSSU_IRC_MIN = 4'h1;
	// Crystal range codes on upper three bits
	localparam logic [2:0] CSSU_RNG_CODE_LOW = 3'h5;
	localparam logic [2:0] CSSU_RNG_CODE_MID = 3'h6;
	// Start-up cycle counts in source cycles
	localparam logic [14:0] CSSU_SU_258 = 15'h0102;
	localparam logic [14:0] CSSU_SU_1K = 15'h0400;
	localparam logic [14:0] CSSU_SU_16K = 15'h4000;
	localparam logic [14:0] CSSU_SU_OTHER = 15'h0006;
	// Reset delays in watchdog cycles
	localparam logic [16:0] CSSU_WD_SHORT = 17'h01000;
	localparam logic [16:0] CSSU_WD_LONG = 17'h10000;
endpackage : cssu_pkg

// file: logic/cssu_top.sv
// Clock source decode, start-up sequencing and per-domain clock gate enables.
// Assumes fuses are static after reset; source and watchdog ticks are asynchronous pin levels.
module cssu_top (
	input wire logic clk,
	input wire logic rst,
	input wire cssu_pkg::cssu_fuse_s fuses,
	input wire logic wake_req,
	input wire cssu_pkg::cssu_gate_s gates,
	input wire logic src_osc,
	input wire logic wdog_osc,
	input wire logic ext_int_async,
	input wire logic twi_addr_match_async,
	output cssu_pkg::cssu_src_e clock_source,
	output cssu_pkg::cssu_rng_e osc_range,
	output logic core_clock,
	output logic peripheral_clock,
	output logic program_memory_clock,
	output logic async_timer_clock,
	output logic converter_clock,
	output logic wake_event,
	output logic startup_busy
);
	import cssu_pkg::*;

	// Sequencer states
	typedef enum logic [3:0] {
		S_RUN = 4'h1,
		S_OSC = 4'h2,
		S_WDOG = 4'h4,
		S_SLEEP = 4'h8
	} cssu_st_e;

	cssu_st_e st_ff; // Sequencer state
	cssu_st_e nxt_st;
	logic [2:0] src_sync_ff; // Oscillator pin synchroniser plus history
	logic [2:0] wd_sync_ff; // Watchdog pin synchroniser plus history
	logic [1:0] irq_sync_ff; // Async interrupt synchroniser
	logic [1:0] twi_sync_ff; // Address match synchroniser
	logic [14:0] osc_cnt_ff; // Source cycles left
	logic [16:0] wd_cnt_ff; // Watchdog cycles left
	logic from_reset_ff; // Reset delay still owed
	cssu_src_e nxt_src;
	cssu_rng_e nxt_rng;
	cssu_dly_e dly_sel;
	logic [14:0] su_cycles;
	logic src_tick;
	logic wd_tick;
	logic [16:0] wd_load;
	logic osc_armed_ff; // Low only on the first edge after reset

	// Edge detect reads only the second and third stages
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			src_sync_ff <= 3'h0;
			wd_sync_ff <= 3'h0;
		end else begin
			src_sync_ff <= {src_sync_ff[1:0], src_osc};
			wd_sync_ff <= {wd_sync_ff[1:0], wdog_osc};
		end
	end
	assign src_tick = src_sync_ff[1] & ~src_sync_ff[2];
	assign wd_tick = wd_sync_ff[1] & ~wd_sync_ff[2];

	// Interrupt and address match synchronisers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_sync_ff <= 2'h0;
			twi_sync_ff <= 2'h0;
		end else begin
			irq_sync_ff <= {irq_sync_ff[0], ext_int_async};
			twi_sync_ff <= {twi_sync_ff[0], twi_addr_match_async};
		end
	end

	// Source decode; fuse value one is unprogrammed, so codes compare as printed
	always_comb begin
		if (fuses.clock_source_select_fuses >= CSSU_XTAL_MIN) begin
			nxt_src = CSSU_SRC_XTAL;
		end else if (fuses.clock_source_select_fuses == CSSU_LF_CODE) begin
			nxt_src = CSSU_SRC_LF_XTAL;
		end else if (fuses.clock_source_select_fuses >= CSSU_ERC_MIN) begin
			nxt_src = CSSU_SRC_EXT_RC;
		end else if (fuses.clock_source_select_fuses >= CSSU_IRC_MIN) begin
			nxt_src = CSSU_SRC_INT_RC;
		end else begin
			nxt_src = CSSU_SRC_EXT_CLK;
		end
	end

	// Amplifier range; programmed swing fuse gives the wide range
	always_comb begin
		if (fuses.oscillator_swing_option_fuse != CSSU_FUSE_UNPROG) begin
			nxt_rng = CSSU_RNG_WIDE;
		end else if (fuses.clock_source_select_fuses[3:1] == CSSU_RNG_CODE_LOW) begin
			nxt_rng = CSSU_RNG_LOW;
		end else if (fuses.clock_source_select_fuses[3:1] == CSSU_RNG_CODE_MID) begin
			nxt_rng = CSSU_RNG_MID;
		end else begin
			nxt_rng = CSSU_RNG_HIGH;
		end
	end

	// Start-up table; only the crystal table is decoded, other sources use a short fixed count
	always_comb begin
		su_cycles = CSSU_SU_OTHER;
		dly_sel = CSSU_DLY_LONG;
		if (nxt_src == CSSU_SRC_XTAL) begin
			unique case ({fuses.clock_source_select_fuses[0], fuses.startup_time_fuses})
				3'h0: begin su_cycles = CSSU_SU_258; dly_sel = CSSU_DLY_SHORT; end
				3'h1: begin su_cycles = CSSU_SU_258; dly_sel = CSSU_DLY_LONG; end
				3'h2: begin su_cycles = CSSU_SU_1K; dly_sel = CSSU_DLY_NONE; end
				3'h3: begin su_cycles = CSSU_SU_1K; dly_sel = CSSU_DLY_SHORT; end
				3'h4: begin su_cycles = CSSU_SU_1K; dly_sel = CSSU_DLY_LONG; end
				3'h5: begin su_cycles = CSSU_SU_16K; dly_sel = CSSU_DLY_NONE; end
				3'h6: begin su_cycles = CSSU_SU_16K; dly_sel = CSSU_DLY_SHORT; end
				3'h7: begin su_cycles = CSSU_SU_16K; dly_sel = CSSU_DLY_LONG; end
			endcase
		end
	end
	assign wd_load = (dly_sel == CSSU_DLY_LONG) ? CSSU_WD_LONG : CSSU_WD_SHORT;

	// Sequencer: sleep, oscillator start-up, then watchdog delay when coming from reset
	always_comb begin
		nxt_st = st_ff;
		unique case (st_ff)
			S_RUN: if (wake_req == 1'b0 && gates.core_run == 1'b0) nxt_st = S_SLEEP;
			S_SLEEP: if (wake_req) nxt_st = S_OSC;
			S_OSC: begin
				if (osc_cnt_ff == 15'h0) begin
					if (from_reset_ff && dly_sel != CSSU_DLY_NONE) nxt_st = S_WDOG;
					else nxt_st = S_RUN;
				end
			end
			S_WDOG: if (wd_cnt_ff == 17'h0) nxt_st = S_RUN;
			default: nxt_st = S_OSC;
		endcase
	end

	// State register; reset restarts the whole start-up
	always_ff @(posedge clk or posedge rst) begin
		if (rst) st_ff <= S_OSC;
		else st_ff <= nxt_st;
	end

	// Reset-owed flag cleared once the sequence first completes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) from_reset_ff <= 1'b1;
		else if (nxt_st == S_RUN) from_reset_ff <= 1'b0;
	end

	// Arms the start-up count once; a reset value cannot carry the fuse-dependent count
	always_ff @(posedge clk or posedge rst) begin
		if (rst) osc_armed_ff <= 1'b0;
		else osc_armed_ff <= 1'b1;
	end

	// Oscillator cycle counter loaded on the first edge after reset and whenever the sequencer is outside S_OSC
	always_ff @(posedge clk or posedge rst) begin
		if (rst) osc_cnt_ff <= CSSU_SU_16K;
		else if (!osc_armed_ff || st_ff != S_OSC) osc_cnt_ff <= su_cycles;
		else if (src_tick && osc_cnt_ff != 15'h0) osc_cnt_ff <= osc_cnt_ff - 15'h1;
	end

	// Watchdog counter runs only after the oscillator count finished
	always_ff @(posedge clk or posedge rst) begin
		if (rst) wd_cnt_ff <= CSSU_WD_LONG;
		else if (st_ff != S_WDOG) wd_cnt_ff <= wd_load;
		else if (wd_tick && wd_cnt_ff != 17'h0) wd_cnt_ff <= wd_cnt_ff - 17'h1;
	end

	// Decode results registered for clean outputs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			clock_source <= CSSU_SRC_INT_RC;
			osc_range <= CSSU_RNG_HIGH;
		end else begin
			clock_source <= nxt_src;
			osc_range <= nxt_rng;
		end
	end

	// Domain enables; each gated on its own, but sleep always stops core, program memory and peripheral
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			core_clock <= 1'b0;
			program_memory_clock <= 1'b0;
			peripheral_clock <= 1'b0;
			async_timer_clock <= 1'b0;
			converter_clock <= 1'b0;
			startup_busy <= 1'b1;
		end else begin
			core_clock <= (nxt_st == S_RUN) && gates.core_run;
			program_memory_clock <= (nxt_st == S_RUN) && gates.core_run;
			peripheral_clock <= (nxt_st == S_RUN) && gates.periph_run;
			async_timer_clock <= gates.async_run;
			converter_clock <= gates.conv_run;
			startup_busy <= (nxt_st == S_OSC) || (nxt_st == S_WDOG);
		end
	end

	// Async interrupt or address match wakes even with peripheral clock off
	always_ff @(posedge clk or posedge rst) begin
		if (rst) wake_event <= 1'b0;
		else wake_event <= (st_ff == S_SLEEP) && (irq_sync_ff[1] || twi_sync_ff[1]);
	end

	// Core must stay stopped while any start-up count is open
	a_core_hold_startup: assert property (@(posedge clk) disable iff (rst)
		(st_ff == S_OSC || st_ff == S_WDOG) |-> !core_clock)
		else $error("core clock ran during start-up");
	// Watchdog phase only follows a finished oscillator count
	a_wdog_after_osc: assert property (@(posedge clk) disable iff (rst)
		(st_ff == S_WDOG && $past(st_ff) == S_OSC) |-> ($past(osc_cnt_ff) == 15'h0))
		else $error("watchdog phase began early");
	// Flash clock follows core clock
	a_flash_follows_core: assert property (@(posedge clk) disable iff (rst)
		program_memory_clock == core_clock)
		else $error("program memory clock differs from core");
	// Programmed swing fuse always gives wide range
	a_swing_wide: assert property (@(posedge clk) disable iff (rst)
		$stable(fuses) && !fuses.oscillator_swing_option_fuse |=> osc_range == CSSU_RNG_WIDE)
		else $error("swing fuse did not select wide range");
	// Crystal codes decode to crystal source
	a_src_xtal_decode: assert property (@(posedge clk) disable iff (rst)
		$stable(fuses) && fuses.clock_source_select_fuses >= 4'ha |=> clock_source == CSSU_SRC_XTAL)
		else $error("crystal code misdecoded");
	// Converter clock independent of core
	a_conv_indep: assert property (@(posedge clk) disable iff (rst)
		gates.conv_run |=> converter_clock)
		else $error("converter clock stopped");
	// Async timer clock runs in sleep
	a_async_in_sleep: assert property (@(posedge clk) disable iff (rst)
		(st_ff == S_SLEEP && gates.async_run) |=> async_timer_clock)
		else $error("async timer clock stopped in sleep");
	// Crystal code 0,10 gives 1K with no reset delay
	a_xtal_1k_nodly: assert property (@(posedge clk) disable iff (rst)
		(nxt_src == CSSU_SRC_XTAL && fuses.clock_source_select_fuses[0] == 1'b0 &&
		fuses.startup_time_fuses == 2'h2) |-> (su_cycles == CSSU_SU_1K && dly_sel == CSSU_DLY_NONE))
		else $error("crystal start-up table wrong");
	// Lowest bit one, code 01 gives 16K no delay
	a_xtal_16k_nodly: assert property (@(posedge clk) disable iff (rst)
		(nxt_src == CSSU_SRC_XTAL && fuses.clock_source_select_fuses[0] && fuses.startup_time_fuses == 2'h1)
		|-> (su_cycles == CSSU_SU_16K && dly_sel == CSSU_DLY_NONE))
		else $error("crystal 16K table wrong");
	// Async wake works with peripheral clock off
	a_async_wake: assert property (@(posedge clk) disable iff (rst)
		(st_ff == S_SLEEP && irq_sync_ff[1]) |=> wake_event)
		else $error("async interrupt missed in sleep");
	// Low-frequency crystal code has a single value
	a_src_lf_decode: assert property (@(posedge clk) disable iff (rst)
		$stable(fuses) && fuses.clock_source_select_fuses == CSSU_LF_CODE |=> clock_source == CSSU_SRC_LF_XTAL)
		else $error("low-frequency crystal code misdecoded");
	// Fully programmed source field means external clock
	a_src_ext_decode: assert property (@(posedge clk) disable iff (rst)
		$stable(fuses) && fuses.clock_source_select_fuses < CSSU_IRC_MIN |=> clock_source == CSSU_SRC_EXT_CLK)
		else $error("external clock code misdecoded");
	// Unprogrammed swing fuse with code 101 gives the lowest range
	a_rng_low: assert property (@(posedge clk) disable iff (rst)
		$stable(fuses) && fuses.oscillator_swing_option_fuse == CSSU_FUSE_UNPROG &&
		fuses.clock_source_select_fuses[3:1] == CSSU_RNG_CODE_LOW |=> osc_range == CSSU_RNG_LOW)
		else $error("low crystal range misdecoded");
	// Lowest bit zero, code 00 gives 258 cycles and the short delay
	a_xtal_258: assert property (@(posedge clk) disable iff (rst)
		(nxt_src == CSSU_SRC_XTAL && fuses.clock_source_select_fuses[0] == 1'b0 &&
		fuses.startup_time_fuses == 2'h0) |-> (su_cycles == CSSU_SU_258 && dly_sel == CSSU_DLY_SHORT))
		else $error("crystal 258 table wrong");
	// Lowest bit one, code 00 gives 1K cycles and the long delay
	a_xtal_1k_long: assert property (@(posedge clk) disable iff (rst)
		(nxt_src == CSSU_SRC_XTAL && fuses.clock_source_select_fuses[0] && fuses.startup_time_fuses == 2'h0)
		|-> (su_cycles == CSSU_SU_1K && dly_sel == CSSU_DLY_LONG))
		else $error("crystal 1K table wrong");
	// Sleep stops core, program memory and peripheral domains
	a_sleep_gates_off: assert property (@(posedge clk) disable iff (rst)
		st_ff == S_SLEEP |-> (!core_clock && !peripheral_clock && !program_memory_clock))
		else $error("core or peripheral clock ran in sleep");

	// Start-up steps: oscillator count done, watchdog count done, core released
	sequence s_osc_done;
		st_ff == S_OSC && osc_cnt_ff == 15'h0;
	endsequence
	sequence s_wdog_done;
		st_ff == S_WDOG && wd_cnt_ff == 17'h0;
	endsequence
	sequence s_core_up;
		st_ff == S_RUN && !startup_busy;
	endsequence
	// Reset start goes on to the watchdog count when the table asks for one
	a_osc_to_wdog: assert property (@(posedge clk) disable iff (rst)
		s_osc_done ##0 (from_reset_ff && dly_sel != CSSU_DLY_NONE) |=> st_ff == S_WDOG)
		else $error("watchdog delay skipped after reset");
	// Wake from sleep releases the core after the oscillator count alone
	a_wake_osc_only: assert property (@(posedge clk) disable iff (rst)
		s_osc_done ##0 !from_reset_ff |=> s_core_up)
		else $error("wake start-up not released");
	// End of the watchdog count releases the core on the next edge
	a_wdog_release: assert property (@(posedge clk) disable iff (rst)
		s_wdog_done |=> s_core_up)
		else $error("core not released after reset delay");
	// Watchdog phase counts one cycle per watchdog edge
	a_wdog_count: assert property (@(posedge clk) disable iff (rst)
		(st_ff == S_WDOG && wd_tick && wd_cnt_ff != 17'h0) |=> wd_cnt_ff == $past(wd_cnt_ff) - 17'h1)
		else $error("watchdog count step wrong");
endmodule : cssu_top

// file: sim/cssu_osc_model.sv
// Behavioural far side: the selected oscillator pin and the watchdog oscillator pin.
// Assumes the bench calls burst() from one process; both pins stand low between bursts.
module cssu_osc_model (
	input wire logic clk,
	output logic src_osc,
	output logic wdog_osc
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pins idle low, so no stray edge is counted outside a burst
	initial begin
		src_osc = 1'h0;
		wdog_osc = 1'h0;
	end
	// Emit n full cycles on one pin, hp clocks per half period (hp of 2 is the legal minimum)
	task automatic burst(input bit wd, input int n, input int hp);
		repeat (n) begin
			repeat (hp) @(negedge clk);
			if (wd) wdog_osc = 1'h1;
			else src_osc = 1'h1;
			repeat (hp) @(negedge clk);
			if (wd) wdog_osc = 1'h0;
			else src_osc = 1'h0;
		end
	endtask : burst
endmodule : cssu_osc_model

// file: sim/tb.sv
// Self-checking bench for the clock source select and start-up block.
// Assumes the oscillator model drives both pins; all other inputs change at falling edges.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import cssu_pkg::*;
	logic clk = 1'h0;
	logic rst = 1'h1;
	cssu_fuse_s fuses = '0;
	cssu_gate_s gates = 4'hf;
	logic wake_req = 1'h1;
	logic ext_int_async = 1'h0;
	logic twi_addr_match_async = 1'h0;
	logic src_osc, wdog_osc, core_clock, peripheral_clock, program_memory_clock;
	logic async_timer_clock, converter_clock, wake_event, startup_busy;
	cssu_src_e clock_source;
	cssu_rng_e osc_range;
	int n_mismatch = 0; // Mismatch count
	int tests_run = 0; // Comparison count
	// 20 MHz clock
	always #25 clk = ~clk;
	cssu_top i_cssu_top (.clk(clk), .rst(rst), .fuses(fuses), .wake_req(wake_req), .gates(gates),
		.src_osc(src_osc), .wdog_osc(wdog_osc), .ext_int_async(ext_int_async),
		.twi_addr_match_async(twi_addr_match_async), .clock_source(clock_source), .osc_range(osc_range),
		.core_clock(core_clock), .peripheral_clock(peripheral_clock),
		.program_memory_clock(program_memory_clock), .async_timer_clock(async_timer_clock),
		.converter_clock(converter_clock), .wake_event(wake_event), .startup_busy(startup_busy));
	cssu_osc_model i_cssu_osc_model (.clk(clk), .src_osc(src_osc), .wdog_osc(wdog_osc));
	// Expected source from the fuse code
	function automatic logic [3:0] exp_src(input logic [3:0] c);
		if (c >= 4'ha) return 4'h4;
		if (c == 4'h9) return 4'h3;
		if (c >= 4'h5) return 4'h2;
		if (c >= 4'h1) return 4'h1;
		return 4'h0;
	endfunction : exp_src
	// Expected crystal range; swing fuse at zero means programmed
	function automatic logic [3:0] exp_rng(input logic [3:0] c, input logic opt);
		if (!opt) return 4'h3;
		if (c[3:1] == 3'h5) return 4'h0;
		if (c[3:1] == 3'h6) return 4'h1;
		return 4'h2;
	endfunction : exp_rng
	// Start-up source cycles; non-crystal sources use the fixed short count
	function automatic int su_src(input logic [3:0] c, input logic [1:0] s);
		if (c < 4'ha) return 6;
		if (!c[0] && !s[1]) return 258;
		if (!c[0] || s == 2'h0) return 1024;
		return 16384;
	endfunction : su_src
	// Reset delay in watchdog cycles, zero where the table gives none
	function automatic int su_wd(input logic [3:0] c, input logic [1:0] s);
		if (c < 4'ha) return 65536;
		case ({c[0], s})
			3'h2, 3'h5: return 0;
			3'h0, 3'h3, 3'h6: return 4096;
			default: return 65536;
		endcase
	endfunction : su_wd
	// One comparison, reported at once on a miss
	task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// Let synchroniser and edge detect settle, then check start-up state
	task automatic settle_chk(input logic busy);
		repeat (12) @(negedge clk);
		chk("startup_busy", 4'(busy), 4'(startup_busy));
		chk("core_clock", 4'(!busy), 4'(core_clock));
	endtask : settle_chk
	// Six-cycle reset; core held off throughout
	task automatic do_reset();
		rst = 1'h1;
		repeat (6) @(negedge clk);
		chk("core_clock", 4'h0, 4'(core_clock));
		rst = 1'h0;
	endtask : do_reset
	// Oscillator count, then watchdog count, one edge short each time first
	task automatic startup(input logic [3:0] c, input logic [1:0] s);
		int ns;
		int nw;
		int hp;
		ns = su_src(c, s);
		nw = su_wd(c, s);
		hp = $urandom_range(3, 2);
		fuses = {c, s, 1'h1};
		do_reset();
		// Watchdog edges during the oscillator count must be ignored
		i_cssu_osc_model.burst(1'b1, 8, 2);
		i_cssu_osc_model.burst(1'b0, ns - 1, hp);
		settle_chk(1'h1);
		i_cssu_osc_model.burst(1'b0, 1, hp);
		if (nw != 0) begin
			settle_chk(1'h1);
			i_cssu_osc_model.burst(1'b1, nw - 1, 2);
			settle_chk(1'h1);
			i_cssu_osc_model.burst(1'b1, 1, 2);
		end
		settle_chk(1'h0);
	endtask : startup
	// Prints counts and verdict, then stops the run
	task automatic end_of_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	// Hang guard, well beyond the longest expected run
	initial begin
		#(60000 * 50);
		n_mismatch++;
		end_of_test();
	end
	// Main sequence
	initial begin
		void'($urandom(52946)); // Fixed seed, set once
		@(negedge clk);
		fuses = {CSSU_DEF_CKSRC, CSSU_DEF_START, CSSU_FUSE_UNPROG};
		do_reset();
		repeat (3) @(negedge clk);
		chk("clock_source", exp_src(4'h1), 4'(clock_source));
		startup(4'ha, 2'h2);
		// Range 101 with 258 cycles: the far side stands in as a ceramic resonator, not a crystal
		startup(4'ha, 2'h0);
		// Random domain gating while running
		repeat (20) begin
			gates = 4'($urandom);
			repeat (3) @(negedge clk);
			chk("enables", 4'(gates), {core_clock, peripheral_clock, async_timer_clock, converter_clock});
			chk("program_memory_clock", 4'(gates.core_run), 4'(program_memory_clock));
		end
		// Deep sleep with timer and converter domains left on
		gates = 4'h3;
		wake_req = 1'h0;
		repeat (4) @(negedge clk);
		chk("sleep enables", 4'h3, {core_clock, peripheral_clock, async_timer_clock, converter_clock});
		ext_int_async = 1'h1;
		repeat (5) @(negedge clk);
		chk("wake_event", 4'h1, 4'(wake_event));
		ext_int_async = 1'h0;
		twi_addr_match_async = 1'h1;
		repeat (5) @(negedge clk);
		chk("wake_event", 4'h1, 4'(wake_event));
		twi_addr_match_async = 1'h0;
		repeat (5) @(negedge clk);
		chk("wake_event", 4'h0, 4'(wake_event));
		// Wake: oscillator count only, no watchdog delay
		gates = 4'hf;
		wake_req = 1'h1;
		i_cssu_osc_model.burst(1'b0, 257, 3);
		settle_chk(1'h1);
		i_cssu_osc_model.burst(1'b0, 1, 3);
		settle_chk(1'h0);
		// Every fuse code with every start-up and swing setting
		for (int i = 0; i < 128; i++) begin
			fuses = {i[6:3], i[2:1], i[0]};
			repeat (3) @(negedge clk);
			chk("clock_source", exp_src(i[6:3]), 4'(clock_source));
			if (i[6:3] >= 4'ha) chk("osc_range", exp_rng(i[6:3], i[0]), 4'(osc_range));
		end
		end_of_test();
	end
endmodule : tb
